// ### dss_pkg.sv
// package of constants and types for the digit switch scanner
`default_nettype none

package dss_pkg;

  // ----------------------------------------------------------------
  // timing
  // ----------------------------------------------------------------
  localparam int unsigned CLK_PERIOD_NS = 10;
  // one controller scan step
  localparam int unsigned STEP_TIME_NS  = 1000;
  localparam int unsigned STEP_CYCLES   =
    (STEP_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned STEP_CNT_W    = 7;
  localparam logic [STEP_CNT_W-1:0] STEP_LAST =
    STEP_CNT_W'(STEP_CYCLES - 1);
  localparam int unsigned SCAN_STEPS    = 16;
  localparam logic [1:0]  LAST_DIGIT    = 2'h3;

  // ----------------------------------------------------------------
  // register map, byte addresses
  // ----------------------------------------------------------------
  localparam int unsigned ADDR_W      = 8;
  localparam int unsigned DATA_W      = 32;
  localparam logic [7:0] OFS_CTRL     = 8'h00;
  localparam logic [7:0] OFS_DIGITS   = 8'h04;
  localparam logic [7:0] OFS_RESULT0  = 8'h08;
  localparam logic [7:0] OFS_RESULT1  = 8'h0c;
  localparam logic [7:0] OFS_STATUS   = 8'h10;
  localparam logic [7:0] OFS_IRQ_CLR  = 8'h14;
  localparam logic [7:0] OFS_IRQ_EN   = 8'h18;
  localparam logic [7:0] OFS_WORK     = 8'h1c;

  // ----------------------------------------------------------------
  // fields and reset values
  // ----------------------------------------------------------------
  localparam int unsigned CTRL_ENABLE_BIT = 0;
  localparam int unsigned STAT_DONE_BIT   = 0;
  localparam int unsigned STAT_ERR_BIT    = 1;
  localparam int unsigned IN_LOW_LSB      = 0;
  localparam int unsigned IN_HIGH_LSB     = 4;
  localparam logic [15:0] DIGITS_FOUR     = 16'h0000;
  localparam logic [15:0] DIGITS_EIGHT    = 16'h0001;
  localparam logic        CTRL_RST        = 1'b0;
  localparam logic        IRQ_EN_RST      = 1'b0;
  localparam logic [15:0] DIGITS_RST      = DIGITS_FOUR;
  localparam logic [15:0] RESULT_RST      = 16'h0000;

  // ----------------------------------------------------------------
  // types
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    PH_SELECT,
    PH_STROBE,
    PH_SAMPLE,
    PH_RELEASE
  } dss_phase_t;

  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
    logic              wr;
    logic              rd;
  } dss_bus_req_t;

  // output word: bits 00-03 digit selects, 04 read strobe, 05 round flag
  typedef struct packed {
    logic [1:0] spare;
    logic       round;
    logic       rd;
    logic [3:0] cs;
  } dss_out_word_t;

endpackage

`default_nettype wire

// ### dss_scanner.sv
// digit switch scanner: select/strobe drive, nibble capture, registers
//
// Summary of operation
// - control lines on output bits 00 to 04
// - count 0000 hex four digits, 0001 eight
// - four digits in word one, eight span two
// - full read every 16 steps, then restart
// - round flag bit 05 once per scan
// - sample eight data lines from input word
// - fresh start always begins at first step
`default_nettype none

module dss_scanner (
  input  wire logic                  mclk,
  input  wire logic                  rst_b,
  input  wire dss_pkg::dss_bus_req_t bus_req,
  output logic [dss_pkg::DATA_W-1:0] bus_rdata,
  input  wire logic [7:0]            switch_data_lines,
  output dss_pkg::dss_out_word_t     ctrl_word,
  output logic                       irq,
  output logic                       error_flag
);
  import dss_pkg::*;

  // ----------------------------------------------------------------
  // declarations
  // ----------------------------------------------------------------
  logic                  scan_enable;
  logic                  scan_enable_q;
  logic [15:0]           digit_count_select;
  logic [15:0]           result_lo;
  logic [15:0]           result_hi;
  logic [15:0]           shadow_lo;
  logic [15:0]           shadow_hi;
  logic [STEP_CNT_W-1:0] step_cnt;
  dss_phase_t            phase;
  logic [1:0]            digit;
  logic                  round_active;
  logic                  irq_status;
  logic                  irq_enable;
  logic                  step_tick;
  logic                  fresh;
  logic                  running;
  logic                  last_step;
  logic                  eight_mode;
  logic [3:0]            scan_work_word;
  dss_out_word_t         next_ctrl_word;
  logic [DATA_W-1:0]     next_rdata;

  // ----------------------------------------------------------------
  // decode helpers
  // ----------------------------------------------------------------
  function automatic logic hit(input logic [ADDR_W-1:0] a,
                               input logic [ADDR_W-1:0] ofs);
    hit = (a == ofs);
  endfunction

  assign fresh          = scan_enable & ~scan_enable_q;
  assign running        = scan_enable & ~fresh;
  assign step_tick      = running && (step_cnt == STEP_LAST);
  assign last_step      = step_tick && phase == PH_RELEASE &&
                          digit == LAST_DIGIT;
  assign eight_mode     = (digit_count_select == DIGITS_EIGHT);
  assign scan_work_word = {digit, phase};

  // ----------------------------------------------------------------
  // register writes
  // ----------------------------------------------------------------
  always_ff @(posedge mclk) begin
    if (!rst_b) begin
      scan_enable <= CTRL_RST;
    end else if (bus_req.wr && hit(bus_req.addr, OFS_CTRL)) begin
      scan_enable <= bus_req.wdata[CTRL_ENABLE_BIT];
    end
  end

  always_ff @(posedge mclk) begin
    if (!rst_b) begin
      digit_count_select <= DIGITS_RST;
    end else if (bus_req.wr && hit(bus_req.addr, OFS_DIGITS)) begin
      digit_count_select <= bus_req.wdata[15:0];
    end
  end

  always_ff @(posedge mclk) begin
    if (!rst_b) begin
      irq_enable <= IRQ_EN_RST;
    end else if (bus_req.wr && hit(bus_req.addr, OFS_IRQ_EN)) begin
      irq_enable <= bus_req.wdata[STAT_DONE_BIT];
    end
  end

  // edge detect of enable, so a fresh start is seen
  always_ff @(posedge mclk) begin
    if (!rst_b) begin
      scan_enable_q <= CTRL_RST;
    end else begin
      scan_enable_q <= scan_enable;
    end
  end

  // ----------------------------------------------------------------
  // step timer
  // ----------------------------------------------------------------
  always_ff @(posedge mclk) begin
    if (!rst_b) begin
      step_cnt <= '0;
    end else if (!running) begin
      step_cnt <= '0;
    end else if (step_tick) begin
      step_cnt <= '0;
    end else begin
      step_cnt <= step_cnt + STEP_CNT_W'(1);
    end
  end

  // ----------------------------------------------------------------
  // scan sequencer: four phases per digit, four digits per scan
  // ----------------------------------------------------------------
  always_ff @(posedge mclk) begin
    if (!rst_b) begin
      phase <= PH_SELECT;
      digit <= 2'h0;
    end else if (!running) begin
      // a new start never resumes a stopped scan
      phase <= PH_SELECT;
      digit <= 2'h0;
    end else if (step_tick) begin
      case (phase)
        PH_SELECT: begin
          phase <= PH_STROBE;
        end
        PH_STROBE: begin
          phase <= PH_SAMPLE;
        end
        PH_SAMPLE: begin
          phase <= PH_RELEASE;
        end
        default: begin
          phase <= PH_SELECT;
          digit <= digit + 2'h1;
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // nibble capture
  // ----------------------------------------------------------------
  // sampled at the end of the strobe so the switch has settled
  always_ff @(posedge mclk) begin
    if (!rst_b) begin
      shadow_lo <= RESULT_RST;
      shadow_hi <= RESULT_RST;
    end else if (step_tick && phase == PH_SAMPLE) begin
      shadow_lo[digit*4 +: 4] <=
        switch_data_lines[IN_LOW_LSB +: 4];
      shadow_hi[digit*4 +: 4] <= switch_data_lines[IN_HIGH_LSB +: 4];
    end
  end

  // results change only on whole scans, never half-updated
  always_ff @(posedge mclk) begin
    if (!rst_b) begin
      result_lo <= RESULT_RST;
      result_hi <= RESULT_RST;
    end else if (last_step) begin
      result_lo <= shadow_lo;
      if (eight_mode) begin
        result_hi <= shadow_hi;
      end
    end
  end

  // ----------------------------------------------------------------
  // round flag and output word
  // ----------------------------------------------------------------
  always_ff @(posedge mclk) begin
    if (!rst_b) begin
      round_active <= 1'b0;
    end else if (!running) begin
      round_active <= 1'b0;
    end else if (last_step) begin
      round_active <= 1'b1;
    end else if (step_tick) begin
      round_active <= 1'b0;
    end
  end

  always_comb begin
    next_ctrl_word = '0;
    if (running) begin
      if (phase != PH_RELEASE) begin
        next_ctrl_word.cs = 4'h1 << digit;
      end
      next_ctrl_word.rd    = (phase == PH_STROBE) ||
                             (phase == PH_SAMPLE);
      next_ctrl_word.round = round_active;
    end
  end

  always_ff @(posedge mclk) begin
    if (!rst_b) begin
      ctrl_word <= '0;
    end else begin
      ctrl_word <= next_ctrl_word;
    end
  end

  // ----------------------------------------------------------------
  // interrupt
  // ----------------------------------------------------------------
  // set beats a clear written in the same cycle
  always_ff @(posedge mclk) begin
    if (!rst_b) begin
      irq_status <= 1'b0;
    end else if (last_step) begin
      irq_status <= 1'b1;
    end else if (bus_req.wr && hit(bus_req.addr, OFS_IRQ_CLR) &&
                 bus_req.wdata[STAT_DONE_BIT]) begin
      irq_status <= 1'b0;
    end
  end

  always_ff @(posedge mclk) begin
    if (!rst_b) begin
      irq <= 1'b0;
    end else begin
      irq <= irq_status & irq_enable;
    end
  end

  // no fault case exists for this scanner; kept for software
  always_ff @(posedge mclk) begin
    if (!rst_b) begin
      error_flag <= 1'b0;
    end else begin
      error_flag <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // read path
  // ----------------------------------------------------------------
  always_comb begin
    next_rdata = '0;
    if (!bus_req.rd) begin
      next_rdata = '0;
    end else if (hit(bus_req.addr, OFS_CTRL)) begin
      next_rdata[CTRL_ENABLE_BIT] = scan_enable;
    end else if (hit(bus_req.addr, OFS_DIGITS)) begin
      next_rdata[15:0] = digit_count_select;
    end else if (hit(bus_req.addr, OFS_RESULT0)) begin
      next_rdata[15:0] = result_lo;
    end else if (hit(bus_req.addr, OFS_RESULT1)) begin
      next_rdata[15:0] = result_hi;
    end else if (hit(bus_req.addr, OFS_STATUS)) begin
      next_rdata[STAT_DONE_BIT] = irq_status;
      next_rdata[STAT_ERR_BIT]  = error_flag;
    end else if (hit(bus_req.addr, OFS_IRQ_EN)) begin
      next_rdata[STAT_DONE_BIT] = irq_enable;
    end else if (hit(bus_req.addr, OFS_WORK)) begin
      // read only; the scan state cannot be disturbed from software
      next_rdata[3:0] = scan_work_word;
    end
  end

  always_ff @(posedge mclk) begin
    if (!rst_b) begin
      bus_rdata <= '0;
    end else begin
      bus_rdata <= next_rdata;
    end
  end

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  property p_ctrl_bits;
    @(posedge mclk) disable iff (!rst_b)
      ctrl_word.spare == 2'h0 && $countones(ctrl_word.cs) <= 1;
  endproperty
  a_ctrl_bits: assert property (p_ctrl_bits)
    else $error("output word drives bits above 05 or two selects");

  property p_eight_hi;
    @(posedge mclk) disable iff (!rst_b)
      last_step && eight_mode |=> result_hi == $past(shadow_hi);
  endproperty
  a_eight_hi: assert property (p_eight_hi)
    else $error("eight digit scan did not fill second result word");

  property p_four_hi;
    @(posedge mclk) disable iff (!rst_b)
      last_step && !eight_mode |=> $stable(result_hi);
  endproperty
  a_four_hi: assert property (p_four_hi)
    else $error("four digit scan changed second result word");

  property p_wrap;
    @(posedge mclk) disable iff (!rst_b)
      last_step && scan_enable |=>
        phase == PH_SELECT && digit == 2'h0 && step_cnt == '0;
  endproperty
  a_wrap: assert property (p_wrap)
    else $error("scan did not restart after sixteenth step");

  property p_round;
    @(posedge mclk) disable iff (!rst_b)
      last_step && scan_enable |=> ##1 ctrl_word.round && digit == 2'h0;
  endproperty
  a_round: assert property (p_round)
    else $error("round flag missing after completed scan");

  property p_round_only;
    @(posedge mclk) disable iff (!rst_b)
      ctrl_word.round |-> $past(phase) == PH_SELECT &&
                          $past(digit) == 2'h0;
  endproperty
  a_round_only: assert property (p_round_only)
    else $error("round flag outside first step of scan");

  property p_sample;
    @(posedge mclk) disable iff (!rst_b)
      step_tick && phase == PH_SAMPLE |=>
        shadow_lo[$past(digit)*4 +: 4] ==
          $past(switch_data_lines[3:0]);
  endproperty
  a_sample: assert property (p_sample)
    else $error("data lines not captured into digit position");

  property p_fresh;
    @(posedge mclk) disable iff (!rst_b)
      fresh |=> phase == PH_SELECT && digit == 2'h0 &&
                step_cnt == '0;
  endproperty
  a_fresh: assert property (p_fresh)
    else $error("fresh start did not begin at the first step");

  property p_strobe_sel;
    @(posedge mclk) disable iff (!rst_b)
      ctrl_word.rd |-> $onehot(ctrl_word.cs) &&
                       ctrl_word.cs == 4'h1 << $past(digit);
  endproperty
  a_strobe_sel: assert property (p_strobe_sel)
    else $error("read strobe without the matching digit select");

  property p_irq;
    @(posedge mclk) disable iff (!rst_b)
      irq_status && irq_enable |=> irq;
  endproperty
  a_irq: assert property (p_irq)
    else $error("enabled status did not raise interrupt");

  c_four: cover property (@(posedge mclk) disable iff (!rst_b)
    last_step && !eight_mode);
  c_eight: cover property (@(posedge mclk) disable iff (!rst_b)
    last_step && eight_mode);
  c_irq: cover property (@(posedge mclk) disable iff (!rst_b)
    $rose(irq));
  c_restart: cover property (@(posedge mclk) disable iff (!rst_b)
    fresh && scan_enable_q == 1'b0 && digit == 2'h0);

endmodule

`default_nettype wire

// ### dss_switch_bank.sv
// behavioural model of the thumbwheel switch bank on the scanner's lines
`default_nettype none

module dss_switch_bank (
  input  wire logic                   mclk,
  input  wire dss_pkg::dss_out_word_t ctrl_word,
  input  wire logic [31:0]            digits,
  input  wire logic [7:0]             latency,
  output logic [7:0]                  switch_data_lines
);
  timeunit 1ns;
  timeprecision 1ps;
  import dss_pkg::*;

  logic [7:0] held     = 8'h5a;
  logic [7:0] wait_cnt = 8'h00;
  logic [7:0] word;

  // ----------------------------------------------------------------
  // digit d on contacts 0-3, digit d+4 on contacts 4-7
  // ----------------------------------------------------------------
  always_comb begin
    case (ctrl_word.cs)
      4'h1:    word = {digits[19:16], digits[3:0]};
      4'h2:    word = {digits[23:20], digits[7:4]};
      4'h4:    word = {digits[27:24], digits[11:8]};
      4'h8:    word = {digits[31:28], digits[15:12]};
      default: word = ~held;
    endcase
  end

  // slow switches settle only after latency clocks of strobe
  always_ff @(posedge mclk) begin
    if (ctrl_word.rd && wait_cnt >= latency) begin
      held <= word;
    end else begin
      // lines not strobed and settled float: invert the held value every clock
      held <= ~held;
    end
    wait_cnt <= ctrl_word.rd ? wait_cnt + 8'h01 : 8'h00;
  end

  assign switch_data_lines = held;
endmodule

`default_nettype wire

// ### dss_scanner_test.sv
// self-checking bench for the digit switch scanner
`default_nettype none

`define CHK(NAME, EXP, GOT) \
  begin \
    tests_run++; \
    if ((GOT) !== (EXP)) begin \
      n_errors++; \
      $display("unexpected %s: expected %h, seen %h", NAME, EXP, GOT); \
    end \
  end

module dss_scanner_test;
  timeunit 1ns;
  timeprecision 1ps;
  import dss_pkg::*;

  logic              mclk = 1'b0;
  logic              rst_b;
  dss_bus_req_t      bus_req;
  logic [DATA_W-1:0] bus_rdata;
  logic [7:0]        switch_data_lines;
  dss_out_word_t     ctrl_word;
  logic              irq;
  logic              error_flag;
  logic [31:0]       digits;
  logic [7:0]        latency;
  logic [DATA_W-1:0] rd_val;
  int                n_errors = 0;
  int                tests_run = 0;

  dss_scanner i_dut (
    .mclk              (mclk),
    .rst_b             (rst_b),
    .bus_req           (bus_req),
    .bus_rdata         (bus_rdata),
    .switch_data_lines (switch_data_lines),
    .ctrl_word         (ctrl_word),
    .irq               (irq),
    .error_flag        (error_flag)
  );

  dss_switch_bank i_bank (
    .mclk              (mclk),
    .ctrl_word         (ctrl_word),
    .digits            (digits),
    .latency           (latency),
    .switch_data_lines (switch_data_lines)
  );

  initial begin
    forever #5 mclk = ~mclk;
  end

  // ----------------------------------------------------------------
  // bus tasks and checks
  // ----------------------------------------------------------------
  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    @(posedge mclk);
    bus_req <= '{addr: a, wdata: v, wr: 1'b1, rd: 1'b0};
    @(posedge mclk);
    bus_req.wr <= 1'b0;
  endtask

  // read data stands only in the cycle after the strobe
  task automatic chk_reg(input string what, input logic [7:0] a,
                         input logic [31:0] exp);
    @(posedge mclk);
    bus_req <= '{addr: a, wdata: 32'h0, wr: 1'b0, rd: 1'b1};
    @(posedge mclk);
    bus_req.rd <= 1'b0;
    #1;
    rd_val = bus_rdata;
    `CHK(what, exp, rd_val)
  endtask

  task automatic results();
    $display("comparisons %0d, mismatches %0d", tests_run, n_errors);
    if (n_errors == 0 && tests_run > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  // follows one scan from a fresh start into the next round
  task automatic scan_check(input logic exp_irq);
    int t;
    int s;
    int d;
    int p;
    int last;
    s = STEP_CYCLES;
    last = 17 * s;
    for (t = 0; t < 10 && ctrl_word.cs !== 4'h1; t++) begin
      @(posedge mclk);
      #1;
    end
    if (ctrl_word.cs !== 4'h1) begin
      n_errors++;
      $display("unexpected scan start: expected 1, seen %h", ctrl_word.cs);
      // skip the walk; the run still ends in the one closing report
      last = 0;
    end
    for (int i = 1; i <= last; i++) begin
      @(posedge mclk);
      #1;
      d = (i / (4 * s)) % 4;
      p = i % (4 * s);
      if (p == s + s / 2) begin
        `CHK("select", 4'(1 << d), ctrl_word.cs)
        `CHK("strobe", 1'b1, ctrl_word.rd)
      end
      if (p == 3 * s + s / 2 && i < 16 * s) begin
        `CHK("release", 5'h00, {ctrl_word.rd, ctrl_word.cs})
      end
      if (i == 16 * s - 1) begin
        `CHK("round early", 1'b0, ctrl_word.round)
      end
      if (i == 16 * s) begin
        `CHK("round", 1'b1, ctrl_word.round)
        `CHK("restart", 4'h1, ctrl_word.cs)
      end
      if (i == 16 * s + 2) begin
        `CHK("irq", exp_irq, irq)
      end
      if (i == 17 * s - 1) begin
        `CHK("round held", 1'b1, ctrl_word.round)
      end
      if (i == 17 * s) begin
        `CHK("round over", 1'b0, ctrl_word.round)
      end
    end
  endtask

  // ----------------------------------------------------------------
  // main sequence; software writes the work word once and reads it back idle
  // ----------------------------------------------------------------
  initial begin
    rst_b = 1'b0;
    bus_req = '0;
    digits = 32'h87654321;
    latency = 8'h00;
    repeat (5) @(posedge mclk);
    rst_b <= 1'b1;
    chk_reg("ctrl reset", OFS_CTRL, 32'h0);
    chk_reg("digits reset", OFS_DIGITS, {16'h0, DIGITS_RST});
    chk_reg("result0 reset", OFS_RESULT0, 32'h0);
    chk_reg("result1 reset", OFS_RESULT1, 32'h0);
    chk_reg("status reset", OFS_STATUS, 32'h0);
    chk_reg("irq enable reset", OFS_IRQ_EN, 32'h0);
    chk_reg("unmapped", 8'h20, 32'h0);
    `CHK("idle outputs", 10'h0, {ctrl_word, irq, error_flag})
    $display("test reset done");

    wr(OFS_DIGITS, {16'h0, DIGITS_EIGHT});
    wr(OFS_IRQ_EN, 32'h1);
    wr(OFS_CTRL, 32'h1);
    scan_check(1'b1);
    wr(OFS_RESULT0, 32'hffff);
    chk_reg("result0 eight", OFS_RESULT0, 32'h4321);
    chk_reg("result1 eight", OFS_RESULT1, 32'h8765);
    chk_reg("status done", OFS_STATUS, 32'h1);
    wr(OFS_IRQ_CLR, 32'h1);
    chk_reg("status cleared", OFS_STATUS, 32'h0);
    `CHK("irq cleared", 1'b0, irq)
    $display("test eight digits done");

    wr(OFS_CTRL, 32'h0);
    repeat (2) @(posedge mclk);
    #1;
    `CHK("stopped", 5'h00, {ctrl_word.rd, ctrl_word.cs})
    wr(OFS_WORK, 32'hf);
    chk_reg("work idle", OFS_WORK, 32'h0);
    @(posedge mclk);
    digits <= 32'h13579075;
    latency <= 8'd60;
    wr(OFS_DIGITS, {16'h0, DIGITS_FOUR});
    wr(OFS_IRQ_EN, 32'h0);
    wr(OFS_CTRL, 32'h1);
    scan_check(1'b0);
    chk_reg("result0 four", OFS_RESULT0, 32'h9075);
    chk_reg("result1 kept", OFS_RESULT1, 32'h8765);
    chk_reg("status four", OFS_STATUS, 32'h1);
    wr(OFS_IRQ_EN, 32'h1);
    repeat (2) @(posedge mclk);
    #1;
    `CHK("irq unmasked", 1'b1, irq)
    `CHK("error flag", 1'b0, error_flag)
    $display("test four digits done");
    results();
  end
endmodule

`default_nettype wire
